/* File: pin_sync.sv */
// Two-flop synchronisers with rising edge detection for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 3
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  // Raw pins
  input  wire logic [W-1:0] i_async,
  // Synchronised level and rising edge pulse
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q, meta_d;   // First stage, read only by the second
      logic sync_q, sync_d;   // Second stage, safe to use
      logic prev_q, prev_d;   // Delayed copy for edge finding

      // Next values of the chain
      always_comb begin
        meta_d = i_async[g];
        sync_d = meta_q;
        prev_d = sync_q;
      end

      // Registers of the chain
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
          prev_q <= prev_d;
        end
      end

      assign o_level[g] = sync_q;
      assign o_rise[g]  = sync_q & ~prev_q;
    end
  endgenerate

endmodule // pin_sync

/* File: synth_chk_sva.sv */
// Checker for latch loading and lock detect
`timescale 1ns/1ps
module synth_chk (
  // Clock and reset
  input wire logic             i_clock,
  input wire logic             i_arst_n,
  // Watched pins and latches
  input wire logic             i_load_strobe,
  input wire logic             o_lock_detect,
  input synth_pkg::ref_latch_t o_ref_latch,
  input synth_pkg::div_latch_t o_div_latch
);
  logic        str_q, str_d; // Strobe level last cycle
  logic [7:0]  age_q, age_d; // Cycles since strobe rose
  logic [10:0] p;            // Programmable count
  logic [6:0]  s;            // Swallow count
  logic [13:0] r;            // Reference count
  logic        lk;           // Lock in status mode
  assign p  = o_div_latch.prog_count;
  assign s  = o_div_latch.swallow_count;
  assign r  = o_ref_latch.ref_count;
  assign lk = o_lock_detect && !o_ref_latch.lock_output_sel;
  // Age saturates so a long idle stays quiet
  always_comb begin
    str_d = i_load_strobe;
    age_d = (i_load_strobe && !str_q) ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
  end
  // Helper registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      str_q <= 1'b0;
      age_q <= 8'h00;
    end else begin
      str_q <= str_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  a_ref_hold: assert property (age_q > 8'h08 |-> $stable(o_ref_latch)) else $error("ref latch moved");
  a_div_hold: assert property (age_q > 8'h08 |-> $stable(o_div_latch)) else $error("div latch moved");
  a_one_latch: assert property (!($changed(o_ref_latch) && $changed(o_div_latch))) else $error("both latched");
  a_lock_p_min: assert property (lk |-> $past(p, 3) >= synth_pkg::P_MIN) else $error("lock with low P");
  a_lock_s_below: assert property (lk |-> $past(s, 3) < $past(p, 3)) else $error("lock with S not below P");
  a_lock_r_min: assert property (lk |-> $past(r, 3) >= synth_pkg::R_MIN) else $error("lock with low R");
  a_lock_late: assert property ($rose(lk) |-> age_q >= 8'h06) else $error("lock too soon");
  a_lock_drop: assert property ($changed(o_div_latch) && !o_ref_latch.lock_output_sel |-> ##[1:3] !o_lock_detect)
    else $error("lock kept over load");
  a_lock_fall: assert property ($fell(lk) |-> age_q < 8'h10) else $error("lock fell unprompted");
endmodule // synth_chk
bind synth_serial_channel_setup synth_chk i_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_load_strobe(i_load_strobe), .o_lock_detect(o_lock_detect), .o_ref_latch(o_ref_latch), .o_div_latch(o_div_latch));

/* File: synth_host.sv */
// Host model driving the three-wire synthesizer programming pins
`timescale 1ns/1ps
module synth_host (
  // Bench clock that paces the pins
  input  wire logic i_clock,
  // Programming pins
  output logic      o_shift_clk,
  output logic      o_serial_data,
  output logic      o_load_strobe
);
  logic transmit_select_n = 1'b1;
  logic receive_select_n  = 1'b1;
  // Pins start low; the shift clock stands still between words
  initial begin
    o_shift_clk   = 1'b0;
    o_serial_data = 1'b0;
    o_load_strobe = 1'b0;
  end
  function automatic logic [18:0] ref_w(input logic m64, input logic [13:0] r);
    return {1'b0, 1'b0, 1'b1, m64, r, synth_pkg::LATCH_SEL_REF};
  endfunction
  // Divider word, select bit in the last place
  function automatic logic [18:0] div_w(input logic [10:0] p, input logic [6:0] s);
    return {p, s, synth_pkg::LATCH_SEL_DIV};
  endfunction
  task automatic send(input logic [18:0] w);
    receive_select_n  <= 1'b0;
    transmit_select_n <= 1'b1;
    // One bit per 80 ns: data, then clock high 40 ns and low 40 ns
    for (int i = 18; i >= 0; i--) begin
      o_serial_data <= w[i];
      repeat (3) @(posedge i_clock);
      o_shift_clk <= 1'b1;
      repeat (5) @(posedge i_clock);
      o_shift_clk <= 1'b0;
      repeat (2) @(posedge i_clock);
    end
    // one strobe after the last edge
    repeat (3) @(posedge i_clock);
    o_load_strobe <= 1'b1;
    repeat (5) @(posedge i_clock);
    o_load_strobe <= 1'b0;
    // Idle line shows the inverse, so stale data cannot pass
    o_serial_data <= ~w[0];
  endtask
endmodule // synth_host

/* File: synth_pkg.sv */
// Shared constants, field layouts and types for the synthesizer serial channel setup block
package synth_pkg;

  // Serial word geometry
  localparam int unsigned WORD_W    = 19;
  localparam int unsigned R_W       = 14;
  localparam int unsigned P_W       = 11;
  localparam int unsigned S_W       = 7;
  localparam int unsigned N_W       = 18;
  localparam int unsigned SETTLE_W  = 16;

  // Latch select values carried in bit 0, the last bit shifted in
  localparam logic LATCH_SEL_REF    = 1'b1;
  localparam logic LATCH_SEL_DIV    = 1'b0;
  localparam int unsigned SEL_POS   = 0;

  // Prescaler moduli and the select value that picks the small one
  localparam logic [7:0] PRESC_LOW  = 8'h40;
  localparam logic [7:0] PRESC_HIGH = 8'h80;
  localparam logic PRESC_SEL_LOW    = 1'b1;

  // Smallest legal counter values
  localparam logic [R_W-1:0] R_MIN  = 14'h0003;
  localparam logic [P_W-1:0] P_MIN  = 11'h003;

  // Reset values
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 16'h03e8;
  localparam logic [WORD_W-1:0]   WORD_RST   = 19'h00000;

  // APB register byte offsets
  localparam logic [7:0] ADDR_REF    = 8'h00;
  localparam logic [7:0] ADDR_DIV    = 8'h04;
  localparam logic [7:0] ADDR_NDIV   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SETTLE = 8'h10;

  // Status bit positions
  localparam int unsigned ST_LOCKED  = 0;
  localparam int unsigned ST_REF_OK  = 1;
  localparam int unsigned ST_DIV_OK  = 2;
  localparam int unsigned ST_RANGE   = 3;

  // Reference latch: operation bits ahead of the reference count
  typedef struct packed {
    logic           cp_current_sel;       // Charge pump current select
    logic           lock_output_sel;      // 0 lock status, 1 divided frequency
    logic           comparator_polarity;  // Phase comparator sense
    logic           presc_sel;            // 1 picks modulus 64
    logic [R_W-1:0] ref_count;            // Reference counter
  } ref_latch_t;

  // Divider latch: programmable and swallow counts
  typedef struct packed {
    logic [P_W-1:0] prog_count;           // Programmable counter
    logic [S_W-1:0] swallow_count;        // Swallow counter
  } div_latch_t;

  // Lock sequencing states
  typedef enum logic [2:0] {
    ST_UNLOCKED = 3'b001,
    ST_SETTLING = 3'b010,
    ST_LOCK     = 3'b100
  } lock_state_t;

endpackage

/* File: synth_serial_channel_setup.sv */
// Synthesizer serial programming port, divider latches, lock sequencing and APB status
//
// Operation
// - VCO divide is prescaler times P plus S
// - Programmable count 11 bits, at least three
// - Swallow count 7 bits, below programmable count
// - Reference count 14 bits, three to 16383
// - 19-bit shift, last bit picks latch
// - Shift data on programming clock rising edge
// - Load strobe rise copies word to latch
// - Lock detect high locked, low unlocked
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module synth_serial_channel_setup (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  // Programming pins from the host
  input  wire logic        i_shift_clk,
  input  wire logic        i_serial_data,
  input  wire logic        i_load_strobe,
  // Lock detect or divided output pin
  output logic             o_lock_detect,
  // Latched divider settings toward the loop
  output synth_pkg::ref_latch_t o_ref_latch,
  output synth_pkg::div_latch_t o_div_latch,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr
);

  // Synchronised pins: bit 0 clock, bit 1 data, bit 2 strobe
  logic [2:0] pin_level;
  logic [2:0] pin_rise;

  // Serial shift register and latches
  // A load never clears the shift register; the last 19 bits count
  logic [synth_pkg::WORD_W-1:0] shift_q,   shift_d;
  synth_pkg::ref_latch_t        ref_q,     ref_d;
  synth_pkg::div_latch_t        div_q,     div_d;
  logic                         ref_ok_q,  ref_ok_d;   // Reference word seen
  logic                         div_ok_q,  div_ok_d;   // Divider word seen

  // Lock sequencing
  // One-hot states keep each decode to a single bit
  synth_pkg::lock_state_t         state_q,   state_d;
  logic [synth_pkg::SETTLE_W-1:0] settle_cnt_q, settle_cnt_d;
  logic [synth_pkg::SETTLE_W-1:0] settle_q,  settle_d;     // Software settle time
  logic                           lock_pin_q, lock_pin_d;

  // Divided output for the frequency monitor mode
  logic [synth_pkg::R_W-1:0] fdiv_cnt_q, fdiv_cnt_d;
  logic                      fdiv_q,     fdiv_d;

  // APB answer registers
  logic [31:0] prdata_q,  prdata_d;
  logic        pslverr_q, pslverr_d;

  // Derived values
  logic [7:0]                 modulus;
  logic [synth_pkg::N_W-1:0]  ndiv;
  logic                       range_err;
  logic                       load_evt;
  logic                       shift_rise;   // Programming clock rose
  logic                       data_bit;     // Data level seen with that rise

  // Pin synchronisers, all three share one latency so data lines up with clock
  // A shift and its data bit therefore never split across cycles
  pin_sync #(
    .W        (3)
  ) u_pin_sync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_async  ({i_load_strobe, i_serial_data, i_shift_clk}),
    .o_level  (pin_level),
    .o_rise   (pin_rise)
  );

  // Divide ratio and legality checks on the latched words
  always_comb begin
    modulus = (ref_q.presc_sel == synth_pkg::PRESC_SEL_LOW) ? synth_pkg::PRESC_LOW : synth_pkg::PRESC_HIGH;
    // Widest product fits 18 bits: 128 times 2047 plus 127
    // total divide ratio
    ndiv = synth_pkg::N_W'({10'h000, modulus} * {7'h00, div_q.prog_count}) + synth_pkg::N_W'(div_q.swallow_count);
    // An unloaded latch reads zero and flags here too
    // range checks
    range_err = (div_q.prog_count < synth_pkg::P_MIN)
             || ({4'h0, div_q.swallow_count} >= div_q.prog_count)
             || (ref_q.ref_count < synth_pkg::R_MIN);
  end

  assign load_evt = pin_rise[2];

  // Named views of the synchronised pins; clock and strobe levels go unread
  assign shift_rise = pin_rise[0];
  assign data_bit   = pin_level[1];

  // Shift register and latch next values
  always_comb begin
    shift_d  = shift_q;
    ref_d    = ref_q;
    div_d    = div_q;
    ref_ok_d = ref_ok_q;
    div_ok_d = div_ok_q;
    if (shift_rise) begin
      // newest bit enters at the bottom
      shift_d = {shift_q[synth_pkg::WORD_W-2:0], data_bit};
    end
    // Shift and load may meet; the load takes the word before the shift
    // strobe rise loads a latch
    if (load_evt) begin
      if (shift_q[synth_pkg::SEL_POS] == synth_pkg::LATCH_SEL_REF) begin
        ref_d    = synth_pkg::ref_latch_t'(shift_q[synth_pkg::WORD_W-1:1]);
        ref_ok_d = 1'b1;
      end else begin
        div_d    = synth_pkg::div_latch_t'(shift_q[synth_pkg::WORD_W-1:1]);
        div_ok_d = 1'b1;
      end
    end
  end

  // Shift register and latch registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_q  <= synth_pkg::WORD_RST;
      ref_q    <= '0;
      div_q    <= '0;
      ref_ok_q <= 1'b0;
      div_ok_q <= 1'b0;
    end else begin
      shift_q  <= shift_d;
      ref_q    <= ref_d;
      div_q    <= div_d;
      ref_ok_q <= ref_ok_d;
      div_ok_q <= div_ok_d;
    end
  end

  // Lock sequencing: every load restarts settling, so order of words is free
  // The settle count stands in for the real loop settling time
  always_comb begin
    state_d      = state_q;
    settle_cnt_d = settle_cnt_q;
    case (state_q)
      synth_pkg::ST_UNLOCKED: begin
        // Wait for a load; illegal words never lock
        if (load_evt) begin
          state_d      = synth_pkg::ST_SETTLING;
          settle_cnt_d = '0;
        end
      end
      synth_pkg::ST_SETTLING: begin
        if (load_evt) begin
          settle_cnt_d = '0;
        end else if (settle_cnt_q >= settle_q) begin
          if (ref_ok_q && div_ok_q && !range_err) begin
            state_d = synth_pkg::ST_LOCK;
          end else begin
            state_d = synth_pkg::ST_UNLOCKED;
          end
        end else begin
          settle_cnt_d = settle_cnt_q + synth_pkg::SETTLE_W'(1'b1);
        end
      end
      synth_pkg::ST_LOCK: begin
        // A new word pulls the loop out of lock
        if (load_evt) begin
          state_d      = synth_pkg::ST_SETTLING;
          settle_cnt_d = '0;
        end
      end
      default: begin
        // A corrupt state code falls back to unlocked
        state_d      = synth_pkg::ST_UNLOCKED;
        settle_cnt_d = '0;
      end
    endcase
  end

  // Divided frequency and pin value
  // Free-running; seen only when the divided output is selected
  always_comb begin
    fdiv_cnt_d = fdiv_cnt_q + synth_pkg::R_W'(1'b1);
    fdiv_d     = fdiv_q;
    // Toggle once per reference count, a visible divided rate
    if (fdiv_cnt_q >= ref_q.ref_count) begin
      fdiv_cnt_d = '0;
      fdiv_d     = ~fdiv_q;
    end
    // lock status unless divided output chosen
    lock_pin_d = ref_q.lock_output_sel ? fdiv_q : (state_q == synth_pkg::ST_LOCK);
  end

  // Lock sequencing registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q      <= synth_pkg::ST_UNLOCKED;
      settle_cnt_q <= '0;
    end else begin
      state_q      <= state_d;
      settle_cnt_q <= settle_cnt_d;
    end
  end

  // Divided output and pin registers; the pin reads low through reset
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fdiv_cnt_q   <= '0;
      fdiv_q       <= 1'b0;
      lock_pin_q   <= 1'b0;
    end else begin
      fdiv_cnt_q   <= fdiv_cnt_d;
      fdiv_q       <= fdiv_d;
      lock_pin_q   <= lock_pin_d;
    end
  end

  // APB decode: read data captured in setup, write applied at access
  // Read data leaves a register, so the access phase never waits
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    settle_d  = settle_q;
    if (i_psel && !i_penable) begin
      prdata_d  = '0;
      pslverr_d = 1'b0;
      if (i_paddr == synth_pkg::ADDR_REF) begin
        prdata_d = {14'h0000, ref_q};
      end else if (i_paddr == synth_pkg::ADDR_DIV) begin
        prdata_d = {14'h0000, div_q};
      end else if (i_paddr == synth_pkg::ADDR_NDIV) begin
        prdata_d = {14'h0000, ndiv};
      end else if (i_paddr == synth_pkg::ADDR_STATUS) begin
        prdata_d[synth_pkg::ST_LOCKED] = (state_q == synth_pkg::ST_LOCK);
        prdata_d[synth_pkg::ST_REF_OK] = ref_ok_q;
        prdata_d[synth_pkg::ST_DIV_OK] = div_ok_q;
        prdata_d[synth_pkg::ST_RANGE]  = range_err;
      end else if (i_paddr == synth_pkg::ADDR_SETTLE) begin
        prdata_d = {16'h0000, settle_q};
      end else begin
        // Unmapped offset
        pslverr_d = 1'b1;
      end
    end
    // Only the settle time is writable; other writes are dropped
    if (i_psel && i_penable && i_pwrite && (i_paddr == synth_pkg::ADDR_SETTLE)) begin
      settle_d = i_pwdata[synth_pkg::SETTLE_W-1:0];
    end
  end

  // APB registers
  // Settle time returns to its default on reset; software rewrites it
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
      settle_q  <= synth_pkg::SETTLE_RST;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
      settle_q  <= settle_d;
    end
  end

  // Outputs; the slave never inserts wait states
  // Latches go straight out, one cycle after the load edge
  assign o_pready      = 1'b1;
  assign o_prdata      = prdata_q;
  assign o_pslverr     = pslverr_q;
  assign o_lock_detect = lock_pin_q;
  assign o_ref_latch   = ref_q;
  assign o_div_latch   = div_q;

endmodule // synth_serial_channel_setup

/* File: synth_serial_channel_setup_tb.sv */
// Testbench: APB reads and serial words with expected values
`timescale 1ns/1ps
module synth_serial_channel_setup_tb;
  logic                  clk = 1'b0, rst_n = 1'b0;     // Clock and reset
  logic                  psel = 1'b0, penable = 1'b0;  // APB control
  logic                  pwrite = 1'b0, pready, pslverr, err;
  logic [7:0]            paddr = 8'h00;                // APB address
  logic [31:0]           pwdata = 32'h0, prdata, rd;   // APB data
  logic                  sck, sdat, lstb, lock;        // Serial pins
  synth_pkg::ref_latch_t refl;                         // Latched outputs
  synth_pkg::div_latch_t divl;
  logic [10:0]           p;                            // Expected counts
  logic [6:0]            s;
  logic [31:0]           n;
  logic [18:0]           cw [6];                       // Boundary words
  logic                  cr [6];                       // Range expected
  logic [31:0]           chl [3] = '{32'h0, 32'h39, 32'h44};
  int                    bad_count = 0, compares = 0, cyc = 0;
  // Clock at 125 MHz
  always #4 clk = ~clk;
  synth_serial_channel_setup i_synth_serial_channel_setup (.i_clock(clk), .i_arst_n(rst_n),
    .i_shift_clk(sck), .i_serial_data(sdat), .i_load_strobe(lstb), .o_lock_detect(lock),
    .o_ref_latch(refl), .o_div_latch(divl), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr));
  synth_host i_synth_host (.i_clock(clk), .o_shift_clk(sck), .o_serial_data(sdat), .o_load_strobe(lstb));
  // Verdict and end of run
  task automatic end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // APB transfer, held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Read a register and compare
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // Send a word, then wait out settling, scaled down
  // wait before use
  task automatic load(input logic [18:0] w);
    i_synth_host.send(w);
    repeat (30) @(posedge clk);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, read-only and unmapped places
    rchk("settle", synth_pkg::ADDR_SETTLE, {16'h0, synth_pkg::SETTLE_RST});
    chk("pready", 32'h1, {31'h0, pready});
    rchk("status", synth_pkg::ADDR_STATUS, 32'h8);
    apb(1'b1, synth_pkg::ADDR_REF, 32'h1234);
    rchk("ref", synth_pkg::ADDR_REF, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, synth_pkg::ADDR_SETTLE, 32'h4);
    rchk("settle", synth_pkg::ADDR_SETTLE, 32'h4);
    // Channels 0, 57, 68: 433.075 MHz base, 25 kHz step
    for (int i = 0; i < 3; i++) begin
      n = (32'h69bb3 + 32'h19 * chl[i] - 32'h54c4) / 32'h19;
      p = 11'(n / 32'h40);
      s = 7'(n % 32'h40);
      load(i_synth_host.div_w(p, s));
      if (i == 0) begin
        rchk("status", synth_pkg::ADDR_STATUS, 32'hc);
        load(i_synth_host.ref_w(synth_pkg::PRESC_SEL_LOW, 14'h352));
      end
      rchk("ndiv", synth_pkg::ADDR_NDIV, n);
      rchk("div", synth_pkg::ADDR_DIV, {14'h0, p, s});
      rchk("status", synth_pkg::ADDR_STATUS, 32'h7);
      chk("lock", 32'h1, {31'h0, lock});
    end
    chk("ref_latch", 32'(i_synth_host.ref_w(1'b1, 14'h352) >> 1), 32'(refl));
    chk("div_latch", {14'h0, p, s}, 32'(divl));
    load(i_synth_host.ref_w(~synth_pkg::PRESC_SEL_LOW, 14'h352));
    rchk("ndiv128", synth_pkg::ADDR_NDIV, 32'h80 * p + s);
    // Boundary values of P, S and R
    cw = '{i_synth_host.div_w(11'h3, 7'h2), i_synth_host.div_w(11'h2, 7'h0), i_synth_host.div_w(11'h5, 7'h5),
           i_synth_host.div_w(11'h5, 7'h4), i_synth_host.ref_w(1'b1, 14'h3), i_synth_host.ref_w(1'b1, 14'h2)};
    cr = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      load(i_synth_host.div_w(11'h101, 7'h07));
      load(cw[i]);
      rchk("range", synth_pkg::ADDR_STATUS, cr[i] ? 32'he : 32'h7);
      chk("lock", {31'h0, !cr[i]}, {31'h0, lock});
    end
    // Divided output mode: pin holds for R+1 cycles, then flips
    load({3'b011, 1'b1, 14'h0003, synth_pkg::LATCH_SEL_REF});
    n[0] = lock;
    repeat (4) @(posedge clk);
    chk("fdiv", {31'h0, ~n[0]}, {31'h0, lock});
    // Second reset clears latches
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("div_latch", 32'h0, 32'(divl));
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("status", synth_pkg::ADDR_STATUS, 32'h8);
    end_of_test;
  end
endmodule // synth_serial_channel_setup_tb
